// ==== dsdm_consts.vh ====
`ifndef DSDM_CONSTS_VH
`define DSDM_CONSTS_VH
// Sense source selector codes
`define DSDM_SRC_OFF 3'h0
`define DSDM_SRC_CH1 3'h1
`define DSDM_SRC_CH2 3'h2
`define DSDM_SRC_TEMP 3'h3
`define DSDM_SRC_FAULT 3'h4
`define DSDM_SRC_UNDEF 3'h5
// Select code values
`define DSDM_SEL_CH1 2'h0
`define DSDM_SEL_CH2 2'h1
`define DSDM_SEL_TEMP 2'h2
`define DSDM_SEL_NA 2'h3
// Timing, in microseconds, and clock rate in MHz
`define DSDM_CLK_MHZ 200
`define DSDM_STBY_US 20000
`define DSDM_RETRY_US 2000
`define DSDM_STBY_CYC (`DSDM_STBY_US * `DSDM_CLK_MHZ)
`define DSDM_RETRY_CYC (`DSDM_RETRY_US * `DSDM_CLK_MHZ)
`define DSDM_CNT_W 24
// Device mode codes, one-hot
`define DSDM_MODE_STBY 5'h01
`define DSDM_MODE_SDLY 5'h02
`define DSDM_MODE_DIAG 5'h04
`define DSDM_MODE_ACT 5'h08
`define DSDM_MODE_FLT 5'h10
`endif

// ==== dsdm_chan.v ====
`timescale 1ns/1ps
`include "dsdm_consts.vh"
module dsdm_chan #(
  parameter RETRY_CYC = `DSDM_RETRY_CYC,
  parameter CNT_W = `DSDM_CNT_W
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire on_req,
  input wire diag_en,
  input wire gnd_ok,
  input wire hold_sel,
  input wire overcurrent,
  input wire overtemp,
  input wire vout_high,
  output reg switch_on_reg,
  output reg shut_wait_reg,
  output reg openload_reg,
  output wire fault_detect,
  output wire flag_cond
);
  // Cut to the counter width on purpose; the retry wait must fit CNT_W bits
  localparam [31:0] RETRY_LAST_W = RETRY_CYC - 1;
  localparam [CNT_W-1:0] RETRY_LAST = RETRY_LAST_W[CNT_W-1:0];
  reg [CNT_W-1:0] retry_cnt_reg;
  reg on_req_d_reg;
  reg diag_d_reg;
  wire retry_done;
  wire shut_event;
  wire ol_clear;
  //////////////////////////////////////////////////////////////////////////////
  // shutdown cause
  assign shut_event = switch_on_reg & (overcurrent | overtemp);
  assign retry_done = (retry_cnt_reg == RETRY_LAST);
  assign ol_clear = (diag_d_reg & ~diag_en) | (on_req & ~on_req_d_reg);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      switch_on_reg <= 1'b0;
      shut_wait_reg <= 1'b0;
      openload_reg <= 1'b0;
      retry_cnt_reg <= {CNT_W{1'b0}};
      on_req_d_reg <= 1'b0;
      diag_d_reg <= 1'b0;
    end else if (clk_en) begin
      on_req_d_reg <= on_req;
      diag_d_reg <= diag_en;
      // retry counter restarts while faults persist or latched
      if (!shut_wait_reg || overcurrent || overtemp || hold_sel)
        retry_cnt_reg <= {CNT_W{1'b0}};
      else if (!retry_done)
        retry_cnt_reg <= retry_cnt_reg + 1'b1;
      if (!gnd_ok) begin
        switch_on_reg <= 1'b0;
      end else if (shut_event) begin
        switch_on_reg <= 1'b0;
        shut_wait_reg <= 1'b1;
      // leave fault when clear, unlatched and expired
      end else if (shut_wait_reg) begin
        if (retry_done && !overcurrent && !overtemp && !hold_sel) begin
          shut_wait_reg <= 1'b0;
          switch_on_reg <= on_req;
        end
      end else begin
        switch_on_reg <= on_req;
      end
      // off-state detection only with diag on and enable low
      if (ol_clear)
        openload_reg <= 1'b0;
      else if (diag_en && !on_req && gnd_ok)
        openload_reg <= vout_high;
      else
        openload_reg <= 1'b0;
    end
  end
  assign fault_detect = shut_wait_reg | openload_reg;
  assign flag_cond = fault_detect;
endmodule // dsdm_chan

// ==== dsdm_top.v ====
`timescale 1ns/1ps
`include "dsdm_consts.vh"
module dsdm_top #(
  parameter FIXED_LIMIT = 0,
  parameter STBY_CYC = `DSDM_STBY_CYC,
  parameter RETRY_CYC = `DSDM_RETRY_CYC,
  parameter TEMP_W = 8
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire ch1_on_request,
  input wire ch2_on_request,
  input wire diag_enable,
  input wire sense_select_hi,
  input wire sense_select_lo,
  input wire fault_hold_select,
  input wire gnd_ok,
  input wire ch1_overcurrent,
  input wire ch2_overcurrent,
  input wire ch1_overtemp,
  input wire ch2_overtemp,
  input wire ch1_vout_high,
  input wire ch2_vout_high,
  input wire inverse_current,
  input wire [TEMP_W-1:0] ch1_temp,
  input wire [TEMP_W-1:0] ch2_temp,
  output reg [2:0] sense_source_reg,
  output reg sense_oe_reg,
  output reg [TEMP_W-1:0] sense_temp_reg,
  output wire ch1_fault_flag_out,
  output reg ch1_fault_flag_oe_reg,
  output wire ch2_fault_flag_out,
  output reg ch2_fault_flag_oe_reg,
  output wire ch1_switch_on,
  output wire ch2_switch_on,
  output reg [4:0] mode_reg
);
  localparam [4:0] ST_STBY = `DSDM_MODE_STBY;
  localparam [4:0] ST_SDLY = `DSDM_MODE_SDLY;
  localparam [4:0] ST_DIAG = `DSDM_MODE_DIAG;
  localparam [4:0] ST_ACT = `DSDM_MODE_ACT;
  localparam [4:0] ST_FLT = `DSDM_MODE_FLT;
  localparam CNT_W = `DSDM_CNT_W;
  // Cut to the counter width on purpose; the delay must fit CNT_W bits
  localparam [31:0] STBY_LAST_W = STBY_CYC - 1;
  localparam [CNT_W-1:0] STBY_LAST = STBY_LAST_W[CNT_W-1:0];
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by second
  localparam NSYNC = 13;
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  assign pin_raw = {inverse_current, gnd_ok, fault_hold_select, sense_select_hi, sense_select_lo,
                    diag_enable, ch2_on_request, ch1_on_request, ch2_vout_high, ch1_vout_high,
                    ch2_overtemp, ch1_overtemp, ch2_overcurrent | ch1_overcurrent & 1'b0};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  reg [1:0] oc_s1_reg;
  reg [1:0] oc_s2_reg;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      oc_s1_reg <= 2'h0;
      oc_s2_reg <= 2'h0;
    end else if (clk_en) begin
      oc_s1_reg <= {ch2_overcurrent, ch1_overcurrent};
      oc_s2_reg <= oc_s1_reg;
    end
  end
  wire oc1_s = oc_s2_reg[0];
  wire oc2_s = oc_s2_reg[1];
  wire ot1_s = sync2_reg[1];
  wire ot2_s = sync2_reg[2];
  wire vh1_s = sync2_reg[3];
  wire vh2_s = sync2_reg[4];
  wire en1_s = sync2_reg[5];
  wire en2_s = sync2_reg[6];
  wire dia_s = sync2_reg[7];
  wire sello_s = sync2_reg[8];
  // on fixed-limit variant the high select is ignored, assumed grounded
  wire selhi_s = (FIXED_LIMIT != 0) ? 1'b0 : sync2_reg[9];
  wire hold_s = sync2_reg[10];
  wire gnd_s = sync2_reg[11];
  // inverse current is synchronised but never feeds fault logic
  wire inv_unused = sync2_reg[12] & sync2_reg[0];
  //////////////////////////////////////////////////////////////////////////////
  // two independent channel instances
  wire [1:0] shut_w;
  wire [1:0] ol_w;
  wire [1:0] fd_w;
  wire [1:0] fc_w;
  wire [1:0] sw_w;
  wire [1:0] en_w = {en2_s, en1_s};
  wire [1:0] oc_w = {oc2_s, oc1_s};
  wire [1:0] ot_w = {ot2_s, ot1_s};
  wire [1:0] vh_w = {vh2_s, vh1_s};
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      dsdm_chan #(
        .RETRY_CYC(RETRY_CYC),
        .CNT_W(CNT_W)
      ) u_chan (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .on_req(en_w[gi]),
        .diag_en(dia_s),
        .gnd_ok(gnd_s),
        .hold_sel(hold_s),
        .overcurrent(oc_w[gi]),
        .overtemp(ot_w[gi]),
        .vout_high(vh_w[gi]),
        .switch_on_reg(sw_w[gi]),
        .shut_wait_reg(shut_w[gi]),
        .openload_reg(ol_w[gi]),
        .fault_detect(fd_w[gi]),
        .flag_cond(fc_w[gi])
      );
    end
  endgenerate
  assign ch1_switch_on = sw_w[0];
  assign ch2_switch_on = sw_w[1];
  //////////////////////////////////////////////////////////////////////////////
  // Device mode machine
  reg [CNT_W-1:0] stby_cnt_reg;
  reg [4:0] mode_next;
  wire all_low = ~en1_s & ~en2_s & ~dia_s;
  wire stby_done = (stby_cnt_reg == STBY_LAST);
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      ST_STBY: begin
        if (!all_low)
          mode_next = (en1_s | en2_s) ? ST_ACT : ST_DIAG;
      end
      ST_SDLY: begin
        // standby after delay with inputs still low
        if (!all_low)
          mode_next = (en1_s | en2_s) ? ST_ACT : ST_DIAG;
        else if (stby_done)
          mode_next = ST_STBY;
      end
      default: begin
        if (|shut_w)
          mode_next = ST_FLT;
        else if (all_low)
          mode_next = ST_SDLY;
        else if (en1_s | en2_s)
          mode_next = ST_ACT;
        else
          mode_next = ST_DIAG;
      end
    endcase
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_reg <= ST_SDLY;
      stby_cnt_reg <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      mode_reg <= mode_next;
      // standby delay restarts when condition lost
      if (mode_reg != ST_SDLY || !all_low)
        stby_cnt_reg <= {CNT_W{1'b0}};
      else if (!stby_done)
        stby_cnt_reg <= stby_cnt_reg + 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sense mux and fault flags
  // no diagnostics in standby
  wire diag_live = dia_s & (mode_reg != ST_STBY) & ~inv_unused | dia_s & inv_unused & (mode_reg != ST_STBY);
  wire [1:0] sel = {selhi_s, sello_s};
  wire [TEMP_W-1:0] hot_temp = (ch1_temp > ch2_temp) ? ch1_temp : ch2_temp;
  reg [2:0] src_next;
  always @* begin
    src_next = `DSDM_SRC_OFF;
    if (diag_live) begin
      if (FIXED_LIMIT != 0) begin
        // fixed-limit mux by low select bit
        if (fd_w[sello_s])
          src_next = `DSDM_SRC_FAULT;
        else
          src_next = sello_s ? `DSDM_SRC_CH2 : `DSDM_SRC_CH1;
      end else begin
        case (sel)
          // resistor-set mux; fault level on channel codes
          `DSDM_SEL_CH1: src_next = fd_w[0] ? `DSDM_SRC_FAULT : `DSDM_SRC_CH1;
          `DSDM_SEL_CH2: src_next = fd_w[1] ? `DSDM_SRC_FAULT : `DSDM_SRC_CH2;
          `DSDM_SEL_TEMP: src_next = `DSDM_SRC_TEMP;
          default: src_next = `DSDM_SRC_UNDEF;
        endcase
      end
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sense_source_reg <= `DSDM_SRC_OFF;
      sense_oe_reg <= 1'b0;
      sense_temp_reg <= {TEMP_W{1'b0}};
      ch1_fault_flag_oe_reg <= 1'b0;
      ch2_fault_flag_oe_reg <= 1'b0;
    end else if (clk_en) begin
      sense_source_reg <= src_next;
      sense_oe_reg <= diag_live;
      sense_temp_reg <= hot_temp;
      // per-channel open-drain flags, fixed-limit variant only, pulled low on own fault while diagnostics live
      ch1_fault_flag_oe_reg <= (FIXED_LIMIT != 0) & diag_live & fc_w[0];
      ch2_fault_flag_oe_reg <= (FIXED_LIMIT != 0) & diag_live & fc_w[1];
    end
  end
  assign ch1_fault_flag_out = 1'b0;
  assign ch2_fault_flag_out = 1'b0;
endmodule // dsdm_top

// ==== dsdm_mcu.sv ====
`timescale 1ns/1ps
module dsdm_mcu #(
  parameter FIXED_LIMIT = 0
) (
  input wire clk_sys,
  input wire [4:0] cmd,
  output reg ch1_on_request,
  output reg ch2_on_request,
  output reg diag_enable,
  output reg sense_select_hi,
  output reg sense_select_lo
);
  initial {ch1_on_request, ch2_on_request, diag_enable, sense_select_hi, sense_select_lo} = 5'h00;
  // Pins move just after the edge, never on it, so the sync stage sees clean levels
  always @(posedge clk_sys) begin
    #1;
    {ch1_on_request, ch2_on_request, diag_enable, sense_select_lo} <= {cmd[4:2], cmd[0]};
    sense_select_hi <= FIXED_LIMIT ? 1'b0 : cmd[1];
  end
endmodule // dsdm_mcu

// ==== dsdm_top_chk.sv ====
`timescale 1ns/1ps
module dsdm_top_chk #(
  parameter FIXED_LIMIT = 0
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire ch1_on_request,
  input wire ch2_on_request,
  input wire diag_enable,
  input wire sense_select_hi,
  input wire sense_select_lo,
  input wire gnd_ok,
  input wire [2:0] sense_source_reg,
  input wire sense_oe_reg,
  input wire ch1_switch_on,
  input wire ch2_switch_on,
  input wire [4:0] mode_reg
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Six stable samples cover the two sync stages plus the output register
  a_sense_off_nodiag: assert property ((clk_en && !diag_enable)[*6] |-> !sense_oe_reg && sense_source_reg == 3'h0)
    else $error("sense driven with diagnostics off");
  a_sel_temp_kept: assert property ((FIXED_LIMIT == 0 && clk_en && diag_enable && sense_select_hi
    && !sense_select_lo)[*6] |-> sense_source_reg == 3'h3)
    else $error("temperature code not honoured");
  a_stby_delay_entry: assert property ((clk_en && !ch1_on_request && !ch2_on_request && !diag_enable
    && !mode_reg[4])[*6] |-> mode_reg == 5'h02 || mode_reg == 5'h01)
    else $error("all inputs low but not in standby delay");
  a_standby_no_sense: assert property (mode_reg == 5'h01 |-> !sense_oe_reg)
    else $error("sense driven in standby");
  a_active_on_switch: assert property (ch1_switch_on || ch2_switch_on |-> mode_reg == 5'h08 || mode_reg == 5'h10)
    else $error("switch on outside active mode");
  a_gnd_loss_off: assert property ((clk_en && !gnd_ok)[*6] |-> !ch1_switch_on && !ch2_switch_on)
    else $error("switch on with ground lost");
  a_ch1_off_noreq: assert property ((clk_en && !ch1_on_request)[*6] |-> !ch1_switch_on)
    else $error("channel 1 on without request");
  a_ch2_off_noreq: assert property ((clk_en && !ch2_on_request)[*6] |-> !ch2_switch_on)
    else $error("channel 2 on without request");
  c_fault_mode: cover property (mode_reg == 5'h10);
  c_standby_mode: cover property (mode_reg == 5'h01);
  c_fault_level: cover property (sense_source_reg == 3'h4);
endmodule // dsdm_top_chk
bind dsdm_top dsdm_top_chk #(.FIXED_LIMIT(FIXED_LIMIT)) u_dsdm_top_chk (.clk_sys, .rst_n, .clk_en, .ch1_on_request,
  .ch2_on_request, .diag_enable, .sense_select_hi, .sense_select_lo, .gnd_ok, .sense_source_reg, .sense_oe_reg,
  .ch1_switch_on, .ch2_switch_on, .mode_reg);

// ==== tb_dsdm_top.sv ====
`timescale 1ns/1ps
module tb_dsdm_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg gnd_ok = 1'b1;
  reg hold = 1'b0;
  reg inv = 1'b0;
  reg [4:0] cmd = 5'h00;
  reg [5:0] flt = 6'h00;
  wire en1, en2, dg, sh, sl, oe, s1, s2;
  wire [2:0] src;
  wire [2:0] srcf;
  wire f1, f2;
  wire [7:0] tmp;
  wire [4:0] mode;
  integer mismatches = 0;
  integer comparisons = 0;
  integer i;
  always #2.5 clk_sys = ~clk_sys;
  dsdm_mcu u_dsdm_mcu (.clk_sys(clk_sys), .cmd(cmd), .ch1_on_request(en1), .ch2_on_request(en2),
    .diag_enable(dg), .sense_select_hi(sh), .sense_select_lo(sl));
  dsdm_top #(.STBY_CYC(8), .RETRY_CYC(6)) u_dsdm_top (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .ch1_on_request(en1), .ch2_on_request(en2), .diag_enable(dg), .sense_select_hi(sh), .sense_select_lo(sl),
    .fault_hold_select(hold), .gnd_ok(gnd_ok), .ch1_overcurrent(flt[5]), .ch2_overcurrent(flt[4]),
    .ch1_overtemp(flt[3]), .ch2_overtemp(flt[2]), .ch1_vout_high(flt[1]), .ch2_vout_high(flt[0]),
    .inverse_current(inv), .ch1_temp(8'h10), .ch2_temp(8'h20), .sense_source_reg(src), .sense_oe_reg(oe),
    .sense_temp_reg(tmp), .ch1_fault_flag_out(), .ch1_fault_flag_oe_reg(), .ch2_fault_flag_out(),
    .ch2_fault_flag_oe_reg(), .ch1_switch_on(s1), .ch2_switch_on(s2), .mode_reg(mode));
  // Fixed-limit variant on the same pins, so flags and the ignored high select are seen
  dsdm_top #(.FIXED_LIMIT(1), .STBY_CYC(8), .RETRY_CYC(6)) u_dsdm_top_fixed (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(1'b1), .ch1_on_request(en1), .ch2_on_request(en2), .diag_enable(dg), .sense_select_hi(sh),
    .sense_select_lo(sl), .fault_hold_select(hold), .gnd_ok(gnd_ok), .ch1_overcurrent(flt[5]),
    .ch2_overcurrent(flt[4]), .ch1_overtemp(flt[3]), .ch2_overtemp(flt[2]), .ch1_vout_high(flt[1]),
    .ch2_vout_high(flt[0]), .inverse_current(inv), .ch1_temp(8'h10), .ch2_temp(8'h20), .sense_source_reg(srcf),
    .sense_oe_reg(), .sense_temp_reg(), .ch1_fault_flag_out(), .ch1_fault_flag_oe_reg(f1), .ch2_fault_flag_out(),
    .ch2_fault_flag_oe_reg(f2), .ch1_switch_on(), .ch2_switch_on(), .mode_reg());
  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task fin(input string s);
    $display("test %s done", s);
  endtask
  // Pins pass the partner, two sync stages and a register before they show
  // sense sampled only after settling
  task go(input [4:0] c, input [5:0] f);
    begin
      cmd = c;
      flt = f;
      repeat (8) @(posedge clk_sys);
      #1;
    end
  endtask
  task waitm(input [4:0] m, input integer n);
    begin
      while (mode !== m && n > 0) begin
        @(posedge clk_sys);
        #1;
        n = n - 1;
      end
      chk({3'h0, mode}, {3'h0, m});
      if (mode !== m)
        complete_run;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk({3'h0, mode}, 8'h02);
    waitm(5'h01, 40);
    chk({7'h00, oe}, 8'h00);
    fin("standby");
    for (i = 0; i < 4; i = i + 1) begin
      go({3'b001, i[1:0]}, 6'h00);
      chk({5'h00, src}, (i == 3) ? 8'h05 : i[7:0] + 8'h01);
      if (i == 2)
        chk(tmp, 8'h20);
    end
    chk({3'h0, mode}, 8'h04);
    go(5'h00, 6'h00);
    chk({4'h0, oe, src}, 8'h00);
    chk({3'h0, mode}, 8'h02);
    fin("sense mux");
    go(5'b11100, 6'h00);
    chk({6'h00, s1, s2}, 8'h03);
    chk({3'h0, mode}, 8'h08);
    go(5'b11100, 6'h20);
    chk({6'h00, s1, s2}, 8'h01);
    chk({3'h0, mode}, 8'h10);
    chk({5'h00, src}, 8'h04);
    chk({6'h00, f1, f2}, 8'h02);
    go(5'b11110, 6'h20);
    chk({5'h00, src}, 8'h03);
    chk({5'h00, srcf}, 8'h04);
    hold = 1'b1;
    go(5'b11100, 6'h00);
    go(5'b11100, 6'h00);
    chk({3'h0, mode, s1}, 8'h20);
    hold = 1'b0;
    waitm(5'h08, 40);
    chk({6'h00, s1, s2}, 8'h03);
    fin("fault retry");
    gnd_ok = 1'b0;
    go(5'b11100, 6'h00);
    chk({6'h00, s1, s2}, 8'h00);
    gnd_ok = 1'b1;
    go(5'b11100, 6'h00);
    chk({6'h00, s1, s2}, 8'h03);
    inv = 1'b1;
    go(5'b11100, 6'h00);
    chk({3'h0, s1, s2, src}, 8'h19);
    inv = 1'b0;
    fin("ground and inverse");
    go(5'b00100, 6'h02);
    chk({5'h00, src}, 8'h04);
    chk({6'h00, f1, f2}, 8'h02);
    go(5'b10100, 6'h02);
    chk({5'h00, src}, 8'h01);
    chk({6'h00, f1, f2}, 8'h00);
    fin("open load");
    complete_run;
  end
endmodule // tb_dsdm_top
